// File: rtl/rtcsp_pkg.sv
// Shared constants and types for the serial clock access port
`default_nettype none
package rtcsp_pkg;
  localparam int          BYTE_BITS     = 8;
  localparam int          ADDR_BITS     = 7;
  localparam logic [6:0]  ADDR_WRAP     = 7'h3f;
  localparam logic [6:0]  ADDR_RESET    = 7'h00;
  localparam logic [6:0]  CLK_ADDR_LAST = 7'h07;
  localparam logic [6:0]  NCLK_LAST     = 7'h1f;
  localparam int          ADDR_DC_BIT   = 6;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          SCLK_DIV      = 40;
  localparam longint      REC_TIME_MS   = 210;
  localparam longint      MCLK_HZ       = 250_000_000;
  localparam longint      REC_CYCLES    = REC_TIME_MS * MCLK_HZ / 1000;
  localparam logic [7:0]  DATA_RESET    = 8'h00;

  typedef enum logic [1:0]
  {
    RTCSP_IDLE = 2'b00,
    RTCSP_CMD  = 2'b01,
    RTCSP_DATA = 2'b10,
    RTCSP_DEAD = 2'b11
  } rtcsp_state_type;
endpackage
`default_nettype wire

// File: rtl/rtcsp_if.sv
// Link between the master end and the clock's slave port
`timescale 1ns/1ns
`default_nettype none
interface rtcsp_if;
  logic chip_enable_n;
  logic serial_clock_in;
  logic serial_in;
  logic serial_out_o;
  logic serial_out_oe;
  logic serial_out;

  // Undriven line floats; bench sees it as the pull level
  assign serial_out = serial_out_oe ? serial_out_o : 1'b1;

  modport device
  (
    input  chip_enable_n,
    input  serial_clock_in,
    input  serial_in,
    output serial_out_o,
    output serial_out_oe
  );
  modport master
  (
    output chip_enable_n,
    output serial_clock_in,
    output serial_in,
    input  serial_out
  );
endinterface
`default_nettype wire

// File: rtl/rtcsp_fifo.sv
// Parameterised valid/ready FIFO of flip-flops
`timescale 1ns/1ns
`default_nettype none
module rtcsp_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input  wire logic             i_mclk,
  input  wire logic             i_nrst,
  input  wire logic             i_clr,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rp_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_mclk)
  begin
    if (push)
      mem_r[wp_r] <= i_in_data;
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else if (i_clr)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // rtcsp_fifo
`default_nettype wire

// File: rtl/rtcsp_device.sv
// Slave port of the clock: command decode, burst pointer, freeze, power-fail
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Port acts only while select is low
// - Bytes MSB first, first bit after select
// - Sample on rising, drive on falling edge
// - One clock per bit, eight-bit groups
// - Address bit 6 ignored in decode
// - First bit one writes, zero reads
// - Bits two to eight give start address
// - Pointer advances per byte while selected
// - Pointer wraps from 3Fh to 00h
// - Clock addresses freeze time copy
// - Freeze ends on deselect or non-clock address
// - Power fail aborts, clears pointer, ignores bus
// - Port usable at once after power returns
// - Reset output held for recovery time
// - Master clocks only during transfers
// - Master deselects after the byte flagged last
// - Select fall needed before first operation
// - Output floats while deselected
// - Output floats until read byte ready
// - Pointer increments after each data byte
module rtcsp_device
#(
  parameter longint REC_CYCLES = rtcsp_pkg::REC_CYCLES,
  parameter int     FIFO_DEPTH = rtcsp_pkg::FIFO_DEPTH
)
(
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  rtcsp_if.device         link,
  input  wire logic       i_power_fail,
  input  wire logic [7:0] i_rd_data,
  output logic      [6:0] o_rd_addr,
  output logic            o_wr_valid,
  input  wire logic       i_wr_ready,
  output logic      [6:0] o_wr_addr,
  output logic      [7:0] o_wr_data,
  output logic            o_freeze,
  output logic            o_power_on_reset_n
);
  // ==========================================================
  // Pin synchronisers
  logic [1:0] ce_s_r;
  logic [1:0] sck_s_r;
  logic [1:0] sdi_s_r;
  logic [1:0] pf_s_r;
  logic       sck_d_r;
  logic       ce_d_r;
  logic       pf;
  logic       sel;
  logic       rise;
  logic       fall;

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ce_s_r  <= 2'b11;
      sck_s_r <= 2'b00;
      sdi_s_r <= 2'b00;
      pf_s_r  <= 2'b11;
      sck_d_r <= 1'b0;
      ce_d_r  <= 1'b1;
    end
    else
    begin
      ce_s_r  <= {ce_s_r[0], link.chip_enable_n};
      sck_s_r <= {sck_s_r[0], link.serial_clock_in};
      sdi_s_r <= {sdi_s_r[0], link.serial_in};
      pf_s_r  <= {pf_s_r[0], i_power_fail};
      sck_d_r <= sck_s_r[1];
      ce_d_r  <= ce_s_r[1];
    end
  end

  assign pf   = pf_s_r[1];
  // Power fail masks the whole port, no recovery delay here
  assign sel  = !ce_s_r[1] && !pf;
  assign rise = sel && sck_s_r[1] && !sck_d_r;
  assign fall = sel && !sck_s_r[1] && sck_d_r;

  // ==========================================================
  // Serial engine
  rtcsp_pkg::rtcsp_state_type state_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [6:0] ptr_r;
  logic       wr_r;
  logic       armed_r;
  logic       oe_r;
  logic       sdo_r;
  logic [7:0] rx_byte;
  logic       fifo_rdy;
  logic       push;

  assign rx_byte = {sh_r[6:0], sdi_s_r[1]};
  assign push    = rise && bit_r == 3'd7 && state_r == rtcsp_pkg::RTCSP_DATA
                   && wr_r;

  // Select must fall once after reset before anything is accepted
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      armed_r <= 1'b0;
    else if (!ce_s_r[1] && ce_d_r)
      armed_r <= 1'b1;
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_r <= rtcsp_pkg::RTCSP_IDLE;
      bit_r   <= '0;
      sh_r    <= rtcsp_pkg::DATA_RESET;
      ptr_r   <= rtcsp_pkg::ADDR_RESET;
      wr_r    <= 1'b0;
    end
    else if (pf)
    begin
      state_r <= rtcsp_pkg::RTCSP_DEAD;
      bit_r   <= '0;
      ptr_r   <= rtcsp_pkg::ADDR_RESET;
    end
    else if (!sel || !armed_r)
    begin
      state_r <= rtcsp_pkg::RTCSP_IDLE;
      bit_r   <= '0;
    end
    else
    begin
      // A frame cut by power fail stays dead until deselect: no misframing
      if (state_r == rtcsp_pkg::RTCSP_IDLE)
        state_r <= rtcsp_pkg::RTCSP_CMD;
      if (rise && fifo_rdy && state_r != rtcsp_pkg::RTCSP_DEAD)
      begin
        sh_r  <= rx_byte;
        bit_r <= bit_r + 3'd1;
        if (bit_r == 3'd7)
        begin
          unique case (state_r)
            rtcsp_pkg::RTCSP_CMD:
            begin
              wr_r    <= rx_byte[7];
              // Bit 6 dropped so the map repeats in the upper half
              ptr_r   <= {1'b0, rx_byte[5:0]};
              state_r <= rtcsp_pkg::RTCSP_DATA;
            end
            rtcsp_pkg::RTCSP_DATA:
              ptr_r <= (ptr_r == rtcsp_pkg::ADDR_WRAP) ?
                       rtcsp_pkg::ADDR_RESET : ptr_r + 7'd1;
            default:
              state_r <= rtcsp_pkg::RTCSP_CMD;
          endcase
        end
      end
    end
  end

  // Read path: byte loaded at the falling edge after the address byte
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tx_r  <= rtcsp_pkg::DATA_RESET;
      oe_r  <= 1'b0;
      sdo_r <= 1'b0;
    end
    else if (!sel || state_r != rtcsp_pkg::RTCSP_DATA || wr_r)
    begin
      oe_r  <= 1'b0;
      sdo_r <= 1'b0;
    end
    else if (fall)
    begin
      if (bit_r == 3'd0)
      begin
        tx_r  <= {i_rd_data[6:0], 1'b0};
        sdo_r <= i_rd_data[7];
        oe_r  <= 1'b1;
      end
      else
      begin
        sdo_r <= tx_r[7];
        tx_r  <= {tx_r[6:0], 1'b0};
      end
    end
  end

  assign o_rd_addr          = {1'b0, ptr_r[rtcsp_pkg::ADDR_DC_BIT-1:0]};
  assign link.serial_out_o  = sdo_r;
  assign link.serial_out_oe = oe_r;

  // ==========================================================
  // Freeze of the time copy
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_freeze <= 1'b0;
    else
      o_freeze <= sel && state_r == rtcsp_pkg::RTCSP_DATA
                  && ptr_r[5:0] <= rtcsp_pkg::CLK_ADDR_LAST[5:0];
  end

  // ==========================================================
  // Write words handed to the time-base through the FIFO
  rtcsp_fifo
  #(
    .WIDTH (15),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .i_mclk      (i_mclk),
    .i_nrst      (i_nrst),
    .i_clr       (pf),
    .i_in_valid  (push),
    .o_in_ready  (fifo_rdy),
    .i_in_data   ({o_rd_addr, rx_byte}),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  ({o_wr_addr, o_wr_data})
  );

  // ==========================================================
  // Power-on reset output
  localparam int REC_W = $clog2(REC_CYCLES+1);
  logic [REC_W-1:0] rec_r;
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rec_r              <= '0;
      o_power_on_reset_n <= 1'b0;
    end
    else if (pf)
    begin
      rec_r              <= '0;
      o_power_on_reset_n <= 1'b0;
    end
    else if (rec_r != REC_W'(REC_CYCLES))
      rec_r <= rec_r + 1'b1;
    else
      o_power_on_reset_n <= 1'b1;
  end
endmodule // rtcsp_device
`default_nettype wire

// File: rtl/rtcsp_master.sv
// Master end: mode-0 SPI burst engine with a divided serial clock
`timescale 1ns/1ns
`default_nettype none
module rtcsp_master
#(
  parameter int DIV = rtcsp_pkg::SCLK_DIV
)
(
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  rtcsp_if.master         link,
  input  wire logic       i_start,
  input  wire logic       i_write,
  input  wire logic [6:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_last,
  output logic            o_byte_req,
  output logic            o_busy,
  output logic            o_rvalid,
  output logic      [7:0] o_rdata
);
  logic [15:0] div_r;
  logic        tick;
  logic        sck_r;
  logic        ce_n_r;
  logic        sdi_r;
  logic [7:0]  sh_r;
  logic [2:0]  bit_r;
  logic        cmd_r;
  logic        wr_r;
  logic        last_r;
  logic [1:0]  miso_s_r;

  assign tick       = div_r == 16'(DIV/2 - 1);
  assign o_busy     = !ce_n_r;
  assign o_byte_req = tick && sck_r && bit_r == 3'd7 && !last_r;

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      miso_s_r <= 2'b00;
    else
      miso_s_r <= {miso_s_r[0], link.serial_out};
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      div_r <= '0;
    else
      div_r <= (tick || ce_n_r) ? 16'h0000 : div_r + 16'h0001;
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ce_n_r   <= 1'b1;
      sck_r    <= 1'b0;
      sdi_r    <= 1'b0;
      sh_r     <= 8'h00;
      bit_r    <= '0;
      cmd_r    <= 1'b0;
      wr_r     <= 1'b0;
      last_r   <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata  <= 8'h00;
    end
    else
    begin
      o_rvalid <= 1'b0;
      if (ce_n_r && i_start)
      begin
        ce_n_r <= 1'b0;
        cmd_r  <= 1'b1;
        wr_r   <= i_write;
        last_r <= i_last;
        sh_r   <= {i_write, i_addr};
        sdi_r  <= i_write;
        bit_r  <= '0;
      end
      else if (!ce_n_r && tick)
      begin
        // Clock toggles only while selected
        sck_r <= !sck_r;
        if (!sck_r)
          sh_r <= {sh_r[6:0], miso_s_r[1]};
        else if (bit_r != 3'd7)
        begin
          bit_r <= bit_r + 3'd1;
          sdi_r <= sh_r[7];
        end
        else if (last_r && !cmd_r)
        begin
          ce_n_r <= 1'b1;
          if (!wr_r)
          begin
            o_rvalid <= 1'b1;
            o_rdata  <= sh_r;
          end
        end
        else
        begin
          if (!cmd_r && !wr_r)
          begin
            o_rvalid <= 1'b1;
            o_rdata  <= sh_r;
          end
          cmd_r  <= 1'b0;
          bit_r  <= '0;
          last_r <= i_last;
          sh_r   <= i_wdata;
          sdi_r  <= wr_r ? i_wdata[7] : 1'b0;
        end
      end
    end
  end

  assign link.chip_enable_n   = ce_n_r;
  assign link.serial_clock_in = sck_r;
  assign link.serial_in       = sdi_r;
endmodule // rtcsp_master
`default_nettype wire

// File: tb/rtcsp_sva.sv
// Link checker for the serial access port
`timescale 1ns/1ns
`default_nettype none
module rtcsp_sva
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic chip_enable_n,
  input wire logic serial_clock_in,
  input wire logic serial_in,
  input wire logic serial_out_o,
  input wire logic serial_out_oe
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  logic       sck_q_r;
  logic [9:0] rise_cnt_r;

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst) sck_q_r <= 1'b0;
    else sck_q_r <= serial_clock_in;
  end

  // Rising link edges in this frame; cleared while deselected
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst) rise_cnt_r <= 10'h000;
    else if (chip_enable_n) rise_cnt_r <= 10'h000;
    else if (serial_clock_in && !sck_q_r) rise_cnt_r <= rise_cnt_r + 10'h001;
  end

  a_oe_deselect: assert property (chip_enable_n [*6] |-> !serial_out_oe)
    else $error("output driven while deselected");
  a_sck_idle: assert property (chip_enable_n |-> !serial_clock_in)
    else $error("link clock high outside a frame");
  a_first_edge: assert property ($fell(chip_enable_n) |->
    !serial_clock_in [*8])
    else $error("link clock rose too soon after select");
  a_half_period: assert property ($rose(serial_clock_in) |->
    ##20 $fell(serial_clock_in))
    else $error("link clock high phase wrong length");
  a_sdi_hold: assert property (serial_clock_in && $past(serial_clock_in)
    |-> $stable(serial_in) && $stable(chip_enable_n))
    else $error("input data moved while clock high");
  a_sdo_hold: assert property (serial_clock_in && serial_out_oe &&
    $past(serial_out_oe) |-> $stable(serial_out_o))
    else $error("output data moved while clock high");
  a_oe_late: assert property ($rose(serial_out_oe) |-> !chip_enable_n &&
    !serial_clock_in && rise_cnt_r >= 10'd8)
    else $error("output enabled before a byte was ready");
  a_whole_bytes: assert property ($rose(chip_enable_n) |->
    rise_cnt_r[2:0] == 3'h0 && rise_cnt_r >= 10'd16)
    else $error("frame ended on a partial byte");
endmodule // rtcsp_sva
`default_nettype wire

// File: tb/rtc_spi_slave_access_port_tb.sv
// Self-checking bench: master end facing the clock's slave port
`timescale 1ns/1ns
`default_nettype none
module rtc_spi_slave_access_port_tb;
  localparam int REC = 100;
  logic        i_mclk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        start = 1'b0;
  logic        wr = 1'b0;
  logic        last = 1'b0;
  logic        pfail = 1'b0;
  logic        wr_ready = 1'b1;
  logic [6:0]  addr = 7'h00;
  logic [7:0]  wdata = 8'h00;
  logic        byte_req, busy, rvalid, wr_valid, freeze, por_n, frz_seen;
  logic [7:0]  rdata, wr_data;
  logic [6:0]  rd_addr, wr_addr;
  logic [7:0]  mem [64];
  logic [14:0] wq [$];
  logic [7:0]  rq [$];
  int          n_compared = 0;
  int          miscompares = 0;

  always #2 i_mclk = ~i_mclk;

  rtcsp_if link();
  rtcsp_master i_rtcsp_master
  (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .link(link), .i_start(start),
    .i_write(wr), .i_addr(addr), .i_wdata(wdata), .i_last(last),
    .o_byte_req(byte_req), .o_busy(busy), .o_rvalid(rvalid), .o_rdata(rdata)
  );
  rtcsp_device #(.REC_CYCLES(REC), .FIFO_DEPTH(16)) i_rtcsp_device
  (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .link(link), .i_power_fail(pfail),
    .i_rd_data(mem[rd_addr[5:0]]), .o_rd_addr(rd_addr),
    .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data), .o_freeze(freeze), .o_power_on_reset_n(por_n)
  );
  rtcsp_sva i_rtcsp_sva
  (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .chip_enable_n(link.chip_enable_n),
    .serial_clock_in(link.serial_clock_in), .serial_in(link.serial_in),
    .serial_out_o(link.serial_out_o), .serial_out_oe(link.serial_out_oe)
  );

  always @(posedge i_mclk)
  begin
    if (wr_valid === 1'b1 && wr_ready) wq.push_back({wr_addr, wr_data});
  end

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    chk_byte({7'h00, g}, {7'h00, e});
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Next byte is staged ahead: the master takes it on its byte request
  task automatic xfer(input logic w, input logic [6:0] a, input int n,
                      input logic [7:0] d0);
    int k;
    int t;
    k = 0;
    t = 0;
    frz_seen = 1'b0;
    @(posedge i_mclk);
    start <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d0;
    last <= (n == 1);
    @(posedge i_mclk);
    start <= 1'b0;
    // First data byte and its last flag stay put until the command ends
    do
    begin
      @(negedge i_mclk);
      t++;
      if (freeze === 1'b1) frz_seen = 1'b1;
      if (rvalid === 1'b1) rq.push_back(rdata);
      if (byte_req === 1'b1)
      begin
        k++;
        @(posedge i_mclk);
        wdata <= d0 + 8'(k);
        last <= (k == n - 1);
      end
    end while (busy !== 1'b0 && t < 20000);
    if (t >= 20000)
    begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic chk_words(input logic [6:0] a0, input logic [7:0] d0,
                           input int n);
    int t;
    t = 0;
    while (wq.size() < n && t < 4000)
    begin
      @(posedge i_mclk);
      t++;
    end
    if (t >= 4000)
    begin
      miscompares++;
      complete_run();
    end
    chk_byte(8'(wq.size()), 8'(n));
    for (int i = 0; i < n; i++)
    begin
      chk_byte({1'b0, wq[i][14:8]}, {2'b00, 6'(a0) + 6'(i)});
      chk_byte(wq[i][7:0], d0 + 8'(i));
    end
    wq.delete();
  endtask

  initial
  begin
    for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'h5a;
    repeat (6) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    chk_bit(por_n, 1'b0);
    // Address bit 6 set, burst runs across the wrap point
    xfer(1'b1, 7'h7e, 4, 8'h11);
    chk_words(7'h3e, 8'h11, 4);
    rq.delete();
    xfer(1'b0, 7'h45, 4, 8'h00);
    chk_bit(frz_seen, 1'b1);
    for (int i = 0; i < 4; i++) chk_byte(rq[i], 8'(5 + i) ^ 8'h5a);
    repeat (8) @(posedge i_mclk);
    chk_bit(freeze, 1'b0);
    rq.delete();
    xfer(1'b0, 7'h08, 1, 8'h00);
    chk_bit(frz_seen, 1'b0);
    chk_byte(rq[0], 8'h08 ^ 8'h5a);
    // Sink stalls while a full burst lands in the buffer
    @(posedge i_mclk);
    wr_ready <= 1'b0;
    xfer(1'b1, 7'h20, 16, 8'h40);
    chk_byte(8'(wq.size()), 8'h00);
    @(posedge i_mclk);
    wr_ready <= 1'b1;
    chk_words(7'h20, 8'h40, 16);
    fork
      xfer(1'b1, 7'h30, 4, 8'h90);
      begin
        repeat (400) @(posedge i_mclk);
        pfail <= 1'b1;
      end
    join
    chk_words(7'h00, 8'h00, 0);
    chk_bit(por_n, 1'b0);
    @(posedge i_mclk);
    pfail <= 1'b0;
    fork
      xfer(1'b1, 7'h31, 1, 8'h77);
      begin
        repeat (REC - 10) @(posedge i_mclk);
        chk_bit(por_n, 1'b0);
        repeat (20) @(posedge i_mclk);
        chk_bit(por_n, 1'b1);
      end
    join
    chk_words(7'h31, 8'h77, 1);
    complete_run();
  end
endmodule // rtc_spi_slave_access_port_tb
`default_nettype wire
